// File: verilog/fiix_regs.svh
/*
 Constants of the Format II / store / return-jump execution block:
 codes, memory locations and execution times.
 Assumes a 100 MHz clock; locations are machine word addresses.
*/
`ifndef FIIX_REGS_SVH
`define FIIX_REGS_SVH
// ============================================================
// Function and subfunction codes (octal 75, 76, 77, 50)
`define FIIX_F_STORE_SPECIAL_REG_INSTR    6'h3D
`define FIIX_F_RJP      6'h3E
`define FIIX_F_ILLEGAL  6'h3F
`define FIIX_F_FMT2     6'h28
`define FIIX_S_IN_ACT   6'h01
`define FIIX_S_OUT_ACT  6'h02
`define FIIX_S_EXF_ACT  6'h03
`define FIIX_S_IN_XFR   6'h09
`define FIIX_S_OUT_XFR  6'h0A
`define FIIX_S_EXF_XFR  6'h0B
`define FIIX_S_RTC_EN   6'h0C
// ============================================================
// Memory locations (octal 60, 40, 20, 200, 0, 500, 12)
`define FIIX_BASE_IN    16'h0030
`define FIIX_BASE_OUT   16'h0020
`define FIIX_BASE_EXF   16'h0010
`define FIIX_BASE_HIGH  16'h0080
`define FIIX_FAULT_LO   16'h0000
`define FIIX_FAULT_HI   16'h0140
`define FIIX_RTC_ENTRY  16'h000A
// ============================================================
// Execution times
`define FIIX_CLK_NS     10
`define FIIX_T_SHORT_US 2
`define FIIX_T_MID_US   4
`define FIIX_T_LONG_US  6
`define FIIX_CYC_SHORT  ((`FIIX_T_SHORT_US * 1000) / `FIIX_CLK_NS)
`define FIIX_CYC_MID    ((`FIIX_T_MID_US * 1000) / `FIIX_CLK_NS)
`define FIIX_CYC_LONG   ((`FIIX_T_LONG_US * 1000) / `FIIX_CLK_NS)
`endif

// File: verilog/fiix_pkg.sv
/*
 Types of the Format II / store / return-jump execution block.
 Assumes nothing beyond the constants header.
*/
package fiix_pkg;
	// ============================================================
	// Sequencer states
	typedef enum logic [7:0] {
		S_IDLE = 8'h01,
		S_RD   = 8'h02,
		S_WR   = 8'h04,
		S_RD1  = 8'h08,
		S_WR1  = 8'h10,
		S_RD2  = 8'h20,
		S_WR2  = 8'h40,
		S_WAIT = 8'h80
	} fiix_state_t;
	// ============================================================
	// Operation in progress
	typedef enum logic [6:0] {
		OP_NOP   = 7'h01,
		OP_STORE_SPECIAL_REG_INSTR = 7'h02,
		OP_RJP   = 7'h04,
		OP_FAULT = 7'h08,
		OP_ACT   = 7'h10,
		OP_XFER  = 7'h20,
		OP_RTC   = 7'h40
	} fiix_op_t;
endpackage

// File: verilog/fiix_exec.sv
/*
 Execution unit for store special register, direct return jump, the
 illegal code trap and the Format II channel activate / transfer
 group, plus the real-time clock monitor enable.
 Assumes a same-clock core memory port that answers each request with
 a one-cycle mem_ack, and a processor that pulses start with the
 instruction, program address and operand address, then waits for done.
*/
// How it works
// - Code 75 writes zero plus special register, 4 us
// - Code 75 keeps upper twelve bits of word
// - Code 75 then clears only the active bit
// - Code 76 stores P+1, jumps y+1, 4 us
// - Interrupt-entered return jump stores P itself
// - Code 77 traps to 0 or 500, 2 us
// - Code 50 loads function register with subfunction
// - 50:01 sets input channel active, 2 us
// - 50:02 sets output channel active, 2 us
// - 50:03 sets external function channel active
// - 50:12 copies two words, output active, 6 us
// - 50:13 copies two words, function active, 6 us
// - Transfers never stall channels; processor waits 6 us for done
// - 50:14 enables clock monitor, interrupts on equality
// - Monitor interrupt fetches from location 12
`timescale 1ns/100ps
`include "fiix_regs.svh"

module fiix_exec
	import fiix_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Instruction dispatch
	input  wire logic        start,
	input  wire logic [17:0] instr,
	input  wire logic [15:0] p_addr,
	input  wire logic [15:0] opnd_addr,
	input  wire logic        intr_entry,
	// Special register load and recovery switch pin
	input  wire logic        sr_load,
	input  wire logic [4:0]  sr_data,
	input  wire logic        auto_recovery_sw,
	// Real-time clock words
	input  wire logic [17:0] rtc_word,
	input  wire logic [17:0] rtc_monitor,
	// Core memory
	output logic             mem_req,
	output logic             mem_we,
	output logic [15:0]      mem_addr,
	output logic [17:0]      mem_wdata,
	input  wire logic [17:0] mem_rdata,
	input  wire logic        mem_ack,
	// Sequencing results
	output logic             busy,
	output logic             done,
	output logic             jump,
	output logic [15:0]      jump_addr,
	output logic [6:0]       func_reg,
	output logic [4:0]       special_register,
	// Channel buffer control and clock monitor
	output logic [15:0]      in_active,
	output logic [15:0]      out_active,
	output logic [15:0]      exf_active,
	output logic             rtc_mon_en,
	output logic             rtc_irq
);
	// ============================================================
	// State
	fiix_state_t state, next_state;
	fiix_op_t    op, next_op;
	logic [9:0]  cyc, next_cyc, lim, next_lim;
	logic [5:0]  sub, next_sub;
	logic [3:0]  k, next_k;
	logic [15:0] y, next_y, p, next_p;
	logic [17:0] rd_word, next_rd_word;
	logic        next_mem_req, next_mem_we;
	logic [15:0] next_mem_addr;
	logic [17:0] next_mem_wdata;
	logic        next_busy, next_done, next_jump;
	logic [15:0] next_jump_addr;
	logic [6:0]  next_func_reg;
	logic [4:0]  next_sr;
	logic [15:0] next_in_active, next_out_active, next_exf_active;
	logic        next_rtc_mon_en, next_rtc_irq;
	logic        sw_meta, sw_sync;
	logic [15:0] xbase;

	// ============================================================
	// Switch synchroniser
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sw_meta <= 1'b0;
			sw_sync <= 1'b0;
		end
		else
		begin
			sw_meta <= auto_recovery_sw;
			sw_sync <= sw_meta;
		end
	end

	// ============================================================
	// Buffer control word location for channel k
	always_comb
	begin
		case (sub[1:0])
			2'h1:    xbase = `FIIX_BASE_IN;
			2'h2:    xbase = `FIIX_BASE_OUT;
			default: xbase = `FIIX_BASE_EXF;
		endcase
		// Channels 10-17 sit 200 words higher
		xbase = xbase + (k[3] ? `FIIX_BASE_HIGH : 16'h0000)
			+ {12'h000, k[2:0], 1'b0};
	end

	// ============================================================
	// Sequencer next values
	always_comb
	begin
		next_state      = state;
		next_op         = op;
		next_cyc        = (cyc == 10'h3FF) ? cyc : 10'(cyc + 10'h001);
		next_lim        = lim;
		next_sub        = sub;
		next_k          = k;
		next_y          = y;
		next_p          = p;
		next_rd_word    = rd_word;
		next_mem_req    = mem_req;
		next_mem_we     = mem_we;
		next_mem_addr   = mem_addr;
		next_mem_wdata  = mem_wdata;
		next_busy       = busy;
		next_done       = 1'b0;
		next_jump       = 1'b0;
		next_jump_addr  = jump_addr;
		next_func_reg   = func_reg;
		next_sr         = sr_load ? sr_data : special_register;
		next_in_active  = in_active;
		next_out_active = out_active;
		next_exf_active = exf_active;
		next_rtc_mon_en = rtc_mon_en;
		next_rtc_irq    = 1'b0;
		case (state)
			S_IDLE:
			begin
				next_cyc = 10'h000;
				if (start)
				begin
					next_busy = 1'b1;
					next_cyc  = 10'h001;
					next_y    = opnd_addr;
					next_p    = p_addr;
					next_k    = instr[3:0];
					next_sub  = instr[11:6];
					next_lim  = 10'(`FIIX_CYC_SHORT);
					next_state = S_WAIT;
					next_op   = OP_NOP;
					case (instr[17:12])
						`FIIX_F_STORE_SPECIAL_REG_INSTR:
						begin
							next_op       = OP_STORE_SPECIAL_REG_INSTR;
							next_lim      = 10'(`FIIX_CYC_MID);
							next_state    = S_RD;
							next_mem_req  = 1'b1;
							next_mem_addr = opnd_addr;
						end
						`FIIX_F_RJP:
						begin
							next_op        = OP_RJP;
							next_lim       = 10'(`FIIX_CYC_MID);
							next_state     = S_WR;
							next_mem_req   = 1'b1;
							next_mem_we    = 1'b1;
							next_mem_addr  = opnd_addr;
							next_mem_wdata = {2'b00, intr_entry ? p_addr
								: 16'(p_addr + 16'h0001)};
						end
						`FIIX_F_ILLEGAL:
							next_op = OP_FAULT;
						`FIIX_F_FMT2:
						begin
							next_func_reg = {1'b1, instr[11:6]};
							case (instr[11:6])
								`FIIX_S_IN_ACT, `FIIX_S_OUT_ACT, `FIIX_S_EXF_ACT:
									next_op = OP_ACT;
								`FIIX_S_IN_XFR, `FIIX_S_OUT_XFR, `FIIX_S_EXF_XFR:
								begin
									next_op       = OP_XFER;
									next_lim      = 10'(`FIIX_CYC_LONG);
									next_state    = S_RD1;
									next_mem_req  = 1'b1;
									next_mem_addr = 16'(p_addr + 16'h0001);
								end
								`FIIX_S_RTC_EN:
									next_op = OP_RTC;
								6'h00, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08:
									next_op = OP_FAULT;
								default:
									next_op = OP_NOP;
							endcase
						end
						default:
							next_op = OP_NOP;
					endcase
				end
				else if (rtc_mon_en && rtc_word == rtc_monitor)
				begin
					// One shot: monitor must be re-enabled by software
					next_rtc_irq    = 1'b1;
					next_rtc_mon_en = 1'b0;
					next_jump       = 1'b1;
					next_jump_addr  = `FIIX_RTC_ENTRY;
				end
			end
			S_RD:
				if (mem_ack)
				begin
					next_rd_word   = mem_rdata;
					next_mem_we    = 1'b1;
					next_mem_wdata = {mem_rdata[17:6], 1'b0, special_register};
					next_state     = S_WR;
				end
			S_WR:
				if (mem_ack)
				begin
					next_mem_req = 1'b0;
					next_mem_we  = 1'b0;
					if (op == OP_STORE_SPECIAL_REG_INSTR)
						next_sr[4] = 1'b0;
					next_state   = S_WAIT;
				end
			S_RD1, S_RD2:
				if (mem_ack)
				begin
					next_rd_word   = mem_rdata;
					next_mem_we    = 1'b1;
					next_mem_wdata = mem_rdata;
					next_mem_addr  = (state == S_RD1) ? xbase
						: 16'(xbase + 16'h0001);
					next_state     = (state == S_RD1) ? S_WR1 : S_WR2;
				end
			S_WR1:
				if (mem_ack)
				begin
					next_mem_we   = 1'b0;
					next_mem_addr = 16'(p + 16'h0002);
					next_state    = S_RD2;
				end
			S_WR2:
				if (mem_ack)
				begin
					next_mem_req = 1'b0;
					next_mem_we  = 1'b0;
					next_state   = S_WAIT;
				end
			S_WAIT:
				if (cyc >= 10'(lim - 10'h001))
				begin
					next_done  = 1'b1;
					next_busy  = 1'b0;
					next_state = S_IDLE;
					case (op)
						OP_FAULT:
						begin
							next_jump      = 1'b1;
							next_jump_addr = sw_sync ? `FIIX_FAULT_HI : `FIIX_FAULT_LO;
						end
						OP_RJP:
						begin
							next_jump      = 1'b1;
							next_jump_addr = 16'(y + 16'h0001);
						end
						OP_ACT, OP_XFER:
						begin
							// Flags only; channels keep running throughout
							case (sub[1:0])
								2'h1:    next_in_active[k]  = 1'b1;
								2'h2:    next_out_active[k] = 1'b1;
								default: next_exf_active[k] = 1'b1;
							endcase
							if (op == OP_XFER)
							begin
								next_jump      = 1'b1;
								next_jump_addr = 16'(p + 16'h0003);
							end
						end
						OP_RTC:
							next_rtc_mon_en = 1'b1;
						default:
							next_busy = 1'b0;
					endcase
				end
			default:
				next_state = S_IDLE;
		endcase
	end

	// ============================================================
	// Sequencer registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= S_IDLE;
			op <= OP_NOP;
			cyc <= 10'h000;
			lim <= 10'h001;
			sub <= 6'h00;
			k <= 4'h0;
			y <= 16'h0000;
			p <= 16'h0000;
			rd_word <= 18'h00000;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_addr <= 16'h0000;
			mem_wdata <= 18'h00000;
			busy <= 1'b0;
			done <= 1'b0;
			jump <= 1'b0;
			jump_addr <= 16'h0000;
			func_reg <= 7'h00;
			special_register <= 5'h00;
			in_active <= 16'h0000;
			out_active <= 16'h0000;
			exf_active <= 16'h0000;
			rtc_mon_en <= 1'b0;
			rtc_irq <= 1'b0;
		end
		else
		begin
			state <= next_state;
			op <= next_op;
			cyc <= next_cyc;
			lim <= next_lim;
			sub <= next_sub;
			k <= next_k;
			y <= next_y;
			p <= next_p;
			rd_word <= next_rd_word;
			mem_req <= next_mem_req;
			mem_we <= next_mem_we;
			mem_addr <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
			busy <= next_busy;
			done <= next_done;
			jump <= next_jump;
			jump_addr <= next_jump_addr;
			func_reg <= next_func_reg;
			special_register <= next_sr;
			in_active <= next_in_active;
			out_active <= next_out_active;
			exf_active <= next_exf_active;
			rtc_mon_en <= next_rtc_mon_en;
			rtc_irq <= next_rtc_irq;
		end
	end

	// ============================================================
	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_start_code(logic [5:0] code);
		start && !busy && instr[17:12] == code;
	endsequence

	a_store_low_six: assert property (state == S_WR && op == OP_STORE_SPECIAL_REG_INSTR && mem_we
		|-> mem_wdata[5:0] == {1'b0, special_register})
		else $error("store special register low six bits wrong");
	a_store_keep_up: assert property (state == S_WR && op == OP_STORE_SPECIAL_REG_INSTR
		|-> mem_wdata[17:6] == rd_word[17:6])
		else $error("store special register disturbed upper bits");
	a_sr_active_clr: assert property (state == S_WR && op == OP_STORE_SPECIAL_REG_INSTR && mem_ack && !sr_load
		|=> !special_register[4] && special_register[3:0] == $past(special_register[3:0]))
		else $error("special register active bit handling wrong");
	a_rjp_stored: assert property (s_start_code(`FIIX_F_RJP)
		|=> mem_we && mem_wdata == {2'b00, $past(intr_entry) ? $past(p_addr)
			: 16'($past(p_addr) + 16'h0001)})
		else $error("return jump stored wrong address");
	a_fault_time: assert property (s_start_code(`FIIX_F_ILLEGAL)
		|-> ##200 done && jump && jump_addr == (sw_sync ? `FIIX_FAULT_HI : `FIIX_FAULT_LO))
		else $error("illegal code trap wrong time or vector");
	a_fmt2_decode: assert property (s_start_code(`FIIX_F_FMT2)
		|=> func_reg == {1'b1, $past(instr[11:6])})
		else $error("format two function register load wrong");
	a_xfer_target: assert property (state == S_WR1 && mem_we |-> mem_addr == xbase
		&& mem_wdata == rd_word)
		else $error("transfer wrote wrong buffer control location");
	a_store_special_reg_instr_time: assert property (s_start_code(`FIIX_F_STORE_SPECIAL_REG_INSTR)
		|-> ##[400:1000] done)
		else $error("store special register did not finish in time");
	a_rtc_vector: assert property (rtc_irq |-> jump && jump_addr == `FIIX_RTC_ENTRY
		&& !rtc_mon_en)
		else $error("monitor interrupt vector wrong");
	a_act_flag: assert property (done && op == OP_ACT && sub[1:0] == 2'h1
		|-> in_active[k])
		else $error("input active flag not set");
endmodule

// File: sim/fiix_mem_model.sv
/*
 Behavioural core memory answering the execution block's memory port.
 Assumes each request is held until ack; lat gives the wait before ack.
*/
`timescale 1ns/100ps

module fiix_mem_model
(
	// Clock
	input  wire logic        clk,
	// Request side
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [15:0] mem_addr,
	input  wire logic [17:0] mem_wdata,
	output logic      [17:0] mem_rdata,
	output logic             mem_ack,
	// Cycles of wait before each ack
	input  wire logic [3:0]  lat
);
	logic [17:0] mem [0:1023];
	logic [3:0]  wait_cnt;
	logic [17:0] last;
	// ============================================================
	// Answer path
	assign mem_ack = mem_req && (wait_cnt >= lat);
	// Previous value inverted outside an ack: a sample one cycle late sees the word inverted, two cycles late the word
	assign mem_rdata = mem_ack ? mem[mem_addr[9:0]] : ~last;
	initial
	begin
		wait_cnt = 4'h0;
		last = 18'h00000;
	end
	always @(posedge clk)
	begin
		last <= mem_rdata;
		if (mem_ack)
		begin
			wait_cnt <= 4'h0;
			if (mem_we)
				mem[mem_addr[9:0]] <= mem_wdata;
		end
		else if (mem_req)
			wait_cnt <= wait_cnt + 4'h1;
	end
endmodule

// File: sim/fiix_exec_test.sv
/*
 Self-checking bench of the execution unit with a core memory model.
 Assumes the constants header is on the include path.
*/
`timescale 1ns/100ps
`include "fiix_regs.svh"
`define CHK(got, exp) \
	begin \
		tests_run++; \
		if ((got) !== (exp)) \
		begin \
			$display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); \
			num_errors++; \
		end \
	end

module fiix_exec_test;
	logic        clk, rst_n, start, intr_entry, sr_load, auto_recovery_sw;
	logic [17:0] instr, rtc_word, rtc_monitor, mem_wdata, mem_rdata;
	logic [15:0] p_addr, opnd_addr, mem_addr, jump_addr;
	logic [15:0] in_active, out_active, exf_active, ei, eo, ee;
	logic [4:0]  sr_data, special_register;
	logic [6:0]  func_reg;
	logic [5:0]  sub;
	logic [3:0]  lat;
	logic        mem_req, mem_we, mem_ack, busy, done, jump, rtc_mon_en, rtc_irq, jmp_seen;
	logic [15:0] a, p;
	logic [11:0] bad [7] = '{12'hFC0, 12'hA00, 12'hA04, 12'hA05, 12'hA06, 12'hA07, 12'hA08};
	logic [5:0]  subs [6] = '{6'h01, 6'h02, 6'h03, 6'h09, 6'h0A, 6'h0B};
	int          num_errors, tests_run;
	fiix_exec i_fiix_exec (.clk(clk), .rst_n(rst_n), .start(start), .instr(instr),
		.p_addr(p_addr), .opnd_addr(opnd_addr), .intr_entry(intr_entry), .sr_load(sr_load),
		.sr_data(sr_data), .auto_recovery_sw(auto_recovery_sw), .rtc_word(rtc_word),
		.rtc_monitor(rtc_monitor), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy),
		.done(done), .jump(jump), .jump_addr(jump_addr), .func_reg(func_reg),
		.special_register(special_register), .in_active(in_active),
		.out_active(out_active), .exf_active(exf_active), .rtc_mon_en(rtc_mon_en),
		.rtc_irq(rtc_irq));
	fiix_mem_model i_fiix_mem_model (.clk(clk), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack), .lat(lat));
	// ============================================================
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ============================================================
	// Tasks
	task automatic end_of_test();
		if (num_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Issue one instruction and count cycles from the taking edge to done
	task automatic run_op(input logic [17:0] ins, input logic [15:0] pa, input logic [15:0] y,
		input logic ie, input int n_exp, input logic exact);
		int n;
		@(negedge clk);
		start = 1'b1;
		instr = ins;
		p_addr = pa;
		opnd_addr = y;
		intr_entry = ie;
		@(negedge clk);
		start = 1'b0;
		n = 1;
		while (done !== 1'b1 && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 2000)
		begin
			num_errors++;
			end_of_test();
		end
		if (exact)
			`CHK(n, n_exp)
		else
			`CHK(n >= n_exp, 1'b1)
		`CHK(busy, 1'b0)
		jmp_seen = jump;
	endtask
	// ============================================================
	// Scenarios
	initial
	begin
		{rst_n, start, intr_entry, sr_load, auto_recovery_sw, sr_data} = '0;
		{instr, p_addr, opnd_addr, lat, ei, eo, ee} = '0;
		rtc_word = 18'h00001;
		rtc_monitor = 18'h00000;
		num_errors = 0;
		tests_run = 0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		`CHK({busy, done, jump, in_active, out_active, exf_active, rtc_mon_en}, 52'h0)
		for (int sw = 0; sw < 2; sw++)
		begin
			auto_recovery_sw = sw[0];
			repeat (3) @(negedge clk);
			foreach (bad[i])
			begin
				run_op({bad[i], 6'h00}, 16'h0100, 16'h0000, 1'b0, 200, 1'b1);
				`CHK(jump_addr, sw ? `FIIX_FAULT_HI : `FIIX_FAULT_LO)
				`CHK(jmp_seen, 1'b1)
			end
		end
		sr_load = 1'b1;
		sr_data = 5'h15;
		@(negedge clk);
		sr_load = 1'b0;
		i_fiix_mem_model.mem[16'h0050] = 18'h2AAAA;
		run_op({`FIIX_F_STORE_SPECIAL_REG_INSTR, 12'h000}, 16'h0010, 16'h0050, 1'b0, 400, 1'b1);
		`CHK(i_fiix_mem_model.mem[16'h0050], (18'h2AAAA & 18'h3FFC0) | 18'h00015)
		`CHK(special_register, 5'h05)
		for (int ie = 0; ie < 2; ie++)
		begin
			i_fiix_mem_model.mem[16'h0060] = 18'h3FFFF;
			run_op({`FIIX_F_RJP, 12'h000}, 16'h0123, 16'h0060, ie[0], 400, 1'b1);
			`CHK(i_fiix_mem_model.mem[16'h0060], {2'b00, 16'h0123 + (ie ? 16'h0 : 16'h1)})
			`CHK(jump_addr, 16'h0061)
		end
		foreach (subs[i])
		begin
			for (int k = 5; k < 16; k += 8)
			begin
				sub = subs[i];
				p = 16'h0200;
				// Slow memory on high channel transfers; only checks done comes no earlier than 600 cycles
				lat = (sub[3] && k > 8) ? 4'h3 : 4'h0;
				a = (sub[1:0] == 2'h1) ? `FIIX_BASE_IN : (sub[1:0] == 2'h2) ? `FIIX_BASE_OUT
					: `FIIX_BASE_EXF;
				a = (k < 8) ? a + 16'(2 * k) : a + `FIIX_BASE_HIGH + 16'(2 * (k - 8));
				i_fiix_mem_model.mem[p + 16'h1] = 18'h01000 + 18'(sub);
				i_fiix_mem_model.mem[p + 16'h2] = 18'h02000 + 18'(k);
				run_op({`FIIX_F_FMT2, sub, 2'b00, 4'(k)}, p, 16'h0000, 1'b0,
					sub[3] ? 600 : 200, lat == 4'h0);
				`CHK(func_reg, {1'b1, sub})
				case (sub[1:0])
					2'h1: ei[k] = 1'b1;
					2'h2: eo[k] = 1'b1;
					default: ee[k] = 1'b1;
				endcase
				`CHK({in_active, out_active, exf_active}, {ei, eo, ee})
				if (sub[3])
				begin
					`CHK(i_fiix_mem_model.mem[a], 18'h01000 + 18'(sub))
					`CHK(i_fiix_mem_model.mem[a + 16'h1], 18'h02000 + 18'(k))
					`CHK(jump_addr, p + 16'h3)
				end
			end
		end
		lat = 4'h0;
		run_op({`FIIX_F_FMT2, `FIIX_S_RTC_EN, 6'h07}, p, 16'h0000, 1'b0, 200, 1'b1);
		`CHK(rtc_mon_en, 1'b1)
		rtc_monitor = 18'h00005;
		rtc_word = 18'h00004;
		repeat (3) @(negedge clk);
		`CHK(rtc_irq, 1'b0)
		rtc_word = 18'h00005;
		@(negedge clk);
		`CHK({rtc_irq, jump, rtc_mon_en}, 3'b110)
		`CHK(jump_addr, `FIIX_RTC_ENTRY)
		@(negedge clk);
		`CHK(rtc_irq, 1'b0)
		end_of_test();
	end
endmodule
